// ===== tcc_map.vh
// Register indices, field positions and reset values of the timer channel block.
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// ----------------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index
// ----------------------------------------------------------------------------
`define TCC_IDX_CTRL 8'h20
`define TCC_IDX_CNTH 8'h21
`define TCC_IDX_CNTL 8'h22
`define TCC_IDX_MODH 8'h23
`define TCC_IDX_MODL 8'h24
`define TCC_IDX_CH0C 8'h25
`define TCC_IDX_CH0H 8'h26
`define TCC_IDX_CH0L 8'h27
`define TCC_IDX_CH1C 8'h28
`define TCC_IDX_CH1H 8'h29
`define TCC_IDX_CH1L 8'h2A
`define TCC_IDX_STAT 8'h30
`define TCC_IDX_MASK 8'h31
`define TCC_IDX_LSB 2
`define TCC_IDX_MSB 9

// ----------------------------------------------------------------------------
// Counter control fields
// ----------------------------------------------------------------------------
`define TCC_CTRL_STOP 0
`define TCC_CTRL_RST 1
`define TCC_CTRL_PS_LO 2
`define TCC_CTRL_PS_HI 4
`define TCC_PS_EXT 3'h7
`define TCC_PS_ALL 7'h7F
`define TCC_MOD_RST 16'hFFFF

// ----------------------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------------------
`define TCC_CC_MAX 0
`define TCC_CC_TOV 1
`define TCC_CC_ELA 2
`define TCC_CC_ELB 3
`define TCC_CC_MSA 4
`define TCC_CC_MSB 5
`define TCC_CC_W 6
`define TCC_ELS_OFF 2'h0
`define TCC_ELS_RISE 2'h1
`define TCC_ELS_FALL 2'h2
`define TCC_ELS_ANY 2'h3

// ----------------------------------------------------------------------------
// Interrupt status fields and bus answers
// ----------------------------------------------------------------------------
`define TCC_ST_OVF 2
`define TCC_ST_W 3
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`endif

// ===== tcc_chan.v
// One timer channel: input capture, output compare, overflow toggle and byte interlocks.
`default_nettype none
`include "tcc_map.vh"

module tcc_chan
(
    input wire aclk,
    input wire aresetn,
    input wire tick,
    input wire ovf,
    input wire [15:0] cnt,
    input wire pin_in,
    input wire [`TCC_CC_W-1:0] ctrl,
    input wire wr_hi,
    input wire wr_lo,
    input wire rd_hi,
    input wire rd_lo,
    input wire [7:0] wdata,
    output reg [15:0] value_q,
    output reg event_q,
    output reg pin_out_q,
    output reg pin_oe_q
);

    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg stable_q;
    reg rd_lock_q;
    reg wr_lock_q;
    reg level_q;
    reg max_eff_q;
    wire [1:0] els;
    wire any_ms;
    wire capture_mode;
    wire compare_mode;
    wire changed;
    wire edge_ok;
    wire capture;
    wire hit;

    assign els = {ctrl[`TCC_CC_ELB], ctrl[`TCC_CC_ELA]};
    assign any_ms = ctrl[`TCC_CC_MSA] | ctrl[`TCC_CC_MSB];
    assign capture_mode = ~any_ms & (els != `TCC_ELS_OFF);
    assign compare_mode = any_ms & (els != `TCC_ELS_OFF);
    // A change counts only once the second and third stages agree.
    assign changed = (s2_q == s3_q) & (s3_q != stable_q);
    // Edge selection picks rising, falling or either transition.
    assign edge_ok = ((els == `TCC_ELS_RISE) & s3_q) | ((els == `TCC_ELS_FALL) & ~s3_q) |
                     (els == `TCC_ELS_ANY); // [R1] [R16]
    assign capture = capture_mode & changed & edge_ok & ~rd_lock_q; // [R14]
    // A half-written compare value must not fire a match.
    assign hit = any_ms & tick & (cnt == value_q) & ~wr_lock_q; // [R15] [R17]

    // Pin synchroniser; the first stage feeds only the second.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            stable_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                stable_q <= s3_q;
        end
    end

    // Value register holds no reset; bus writes win over a capture in the same cycle.
    always @(posedge aclk)
    begin
        if (wr_hi)
            value_q[15:8] <= wdata; // [R12]
        if (wr_lo)
            value_q[7:0] <= wdata;
        if (capture && !wr_hi && !wr_lo)
            value_q <= cnt; // [R12] [R13]
    end

    // Byte-order interlocks and the event pulse.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_lock_q <= 1'b0;
            wr_lock_q <= 1'b0;
            event_q <= 1'b0;
        end
        else
        begin
            event_q <= capture | hit; // [R17]
            if (rd_lo)
                rd_lock_q <= 1'b0;
            else if (rd_hi && !any_ms)
                rd_lock_q <= 1'b1; // [R14]
            if (wr_lo)
                wr_lock_q <= 1'b0;
            else if (wr_hi && any_ms)
                wr_lock_q <= 1'b1; // [R15]
        end
    end

    // Output level: overflow toggle beats a same-cycle compare action.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            level_q <= 1'b1;
            max_eff_q <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end
        else
        begin
            if (els == `TCC_ELS_OFF)
                level_q <= ~ctrl[`TCC_CC_MSA]; // [R3]
            else if (compare_mode && ovf && ctrl[`TCC_CC_TOV])
                level_q <= ~level_q; // [R6] [R9]
            else if (compare_mode && hit)
            begin
                case (els) // [R2] [R16]
                    `TCC_ELS_RISE: level_q <= ~level_q;
                    `TCC_ELS_FALL: level_q <= 1'b0;
                    `TCC_ELS_ANY: level_q <= 1'b1;
                    default: level_q <= level_q;
                endcase
            end
            // The forced level is re-evaluated at a period boundary, and cleared at once outside compare mode.
            if (!compare_mode)
                max_eff_q <= 1'b0; // [R7]
            else if (ovf)
                max_eff_q <= ctrl[`TCC_CC_MAX] & ctrl[`TCC_CC_TOV]; // [R10] [R11]
            pin_out_q <= max_eff_q ? 1'b1 : level_q; // [R10]
            pin_oe_q <= compare_mode; // [R3]
        end
    end

endmodule // tcc_chan
`default_nettype wire

// ===== tcc_top.v
// Two-channel timer capture/compare block with its counter and an AXI4-Lite register slave.
//
// Notes on behaviour
// [R1] Capture edge chosen by the edge-select pair.
// [R2] Compare pin action chosen by edge-select pair.
// [R3] Edge-select zero releases pin to general I/O.
// [R4] Reset clears both edge-select bits.
// [R5] Software clears event flag after enabling capture.
// [R6] Overflow toggles compare pin when toggle set.
// [R7] Toggle bit ignored for capture channels.
// [R8] Reset clears the toggle-on-overflow bit.
// [R9] Overflow action beats simultaneous compare action.
// [R10] Max-duty bit forces output fully high; the code does so only while the toggle bit is also set.
// [R11] Max-duty change acts from next period.
// [R12] Readable writable 16-bit channel value register.
// [R13] Channel value registers are not reset.
// [R14] High-byte read blocks captures until low read.
// [R15] High-byte write blocks compares until low write.
// [R16] Edge codes: rise/toggle, fall/clear, both/set.
// [R17] Event flag on capture edge or match.
// [R18] Channel 0 buffered bit disables channel 1.
// [R19] Counter overflows at modulo, restarts from zero.
//
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none
`include "tcc_map.vh"

module tcc_top
(
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ext_clk_pin,
    input wire [1:0] channel_pin_in,
    output wire [1:0] channel_pin_out,
    output wire [1:0] channel_pin_oe,
    output reg irq
);

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------

    // Word index of a byte address.
    function [7:0] tcc_idx;
        input [11:0] addr;
        begin
            tcc_idx = {addr[11:10] == 2'h0 ? addr[`TCC_IDX_MSB:`TCC_IDX_LSB] : 8'hFF};
        end
    endfunction

    // True for an index that holds a register.
    function tcc_mapped;
        input [7:0] idx;
        begin
            case (idx)
                `TCC_IDX_CTRL, `TCC_IDX_CNTH, `TCC_IDX_CNTL, `TCC_IDX_MODH, `TCC_IDX_MODL,
                `TCC_IDX_CH0C, `TCC_IDX_CH0H, `TCC_IDX_CH0L, `TCC_IDX_CH1C, `TCC_IDX_CH1H,
                `TCC_IDX_CH1L, `TCC_IDX_STAT, `TCC_IDX_MASK: tcc_mapped = 1'b1;
                default: tcc_mapped = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg [11:0] awaddr_q;
    reg aw_full_q;
    reg [7:0] wbyte_q;
    reg wlane_q;
    reg w_full_q;
    reg ctrl_stop_q;
    reg ctrl_rst_q;
    reg [2:0] ctrl_ps_q;
    reg [15:0] mod_q;
    reg [15:0] cnt_q;
    reg [6:0] pre_q;
    reg [7:0] cnt_lat_q;
    reg cnt_held_q;
    reg e1_q;
    reg e2_q;
    reg e3_q;
    reg est_q;
    reg [`TCC_CC_W-1:0] cc0_q;
    reg [`TCC_CC_W-2:0] cc1_q;
    reg [`TCC_ST_W-1:0] stat_q;
    reg [`TCC_ST_W-1:0] mask_q;
    reg [7:0] rmux;
    wire wr_go;
    wire rd_go;
    wire [7:0] widx;
    wire [7:0] ridx;
    wire ext_tick;
    wire tick;
    wire ovf;
    wire [6:0] psmask;
    wire [`TCC_CC_W-1:0] cc_eff [0:1];
    wire [15:0] value [0:1];
    wire [1:0] chan_event;
    wire [`TCC_ST_W-1:0] stat_set;
    wire [`TCC_ST_W-1:0] stat_clr;

    assign widx = tcc_idx(awaddr_q);
    assign ridx = tcc_idx(s_axi_araddr);
    // Only the low byte lane carries register data, so a write without it is ignored.
    assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid & wlane_q;
    assign rd_go = s_axi_arvalid & s_axi_arready;

    // ------------------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ------------------------------------------------------------------------

    // Each half is held until both are in; the response then follows.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_q <= 12'h000;
            aw_full_q <= 1'b0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
                w_full_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_full_q && w_full_q && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= tcc_mapped(widx) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------

    // Read data selection; reserved bits read as zero.
    always @*
    begin
        rmux = 8'h00;
        case (ridx)
            `TCC_IDX_CTRL: rmux = {3'h0, ctrl_ps_q, 1'b0, ctrl_stop_q};
            `TCC_IDX_CNTH: rmux = cnt_q[15:8];
            `TCC_IDX_CNTL: rmux = cnt_held_q ? cnt_lat_q : cnt_q[7:0];
            `TCC_IDX_MODH: rmux = mod_q[15:8];
            `TCC_IDX_MODL: rmux = mod_q[7:0];
            `TCC_IDX_CH0C: rmux = {stat_q[0], 1'b0, cc0_q};
            `TCC_IDX_CH0H: rmux = value[0][15:8];
            `TCC_IDX_CH0L: rmux = value[0][7:0];
            `TCC_IDX_CH1C: rmux = {stat_q[1], 2'h0, cc1_q};
            `TCC_IDX_CH1H: rmux = value[1][15:8];
            `TCC_IDX_CH1L: rmux = value[1][7:0];
            `TCC_IDX_STAT: rmux = {5'h00, stat_q};
            `TCC_IDX_MASK: rmux = {5'h00, mask_q};
            default: rmux = 8'h00;
        endcase
    end

    // One read in flight; data is registered on the same edge that takes the address.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TCC_RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rmux};
            s_axi_rresp <= tcc_mapped(ridx) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------

    // Counter and channel control; reset leaves both pins under port control.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_stop_q <= 1'b0;
            ctrl_rst_q <= 1'b0;
            ctrl_ps_q <= 3'h0;
            mod_q <= `TCC_MOD_RST;
            cc0_q <= {`TCC_CC_W{1'b0}}; // [R4] [R8]
            cc1_q <= {(`TCC_CC_W-1){1'b0}}; // [R4] [R8]
            mask_q <= {`TCC_ST_W{1'b0}};
        end
        else
        begin
            ctrl_rst_q <= 1'b0;
            if (wr_go)
            begin
                case (widx)
                    `TCC_IDX_CTRL:
                    begin
                        ctrl_stop_q <= wbyte_q[`TCC_CTRL_STOP];
                        ctrl_rst_q <= wbyte_q[`TCC_CTRL_RST];
                        ctrl_ps_q <= wbyte_q[`TCC_CTRL_PS_HI:`TCC_CTRL_PS_LO];
                    end
                    `TCC_IDX_MODH: mod_q[15:8] <= wbyte_q;
                    `TCC_IDX_MODL: mod_q[7:0] <= wbyte_q;
                    `TCC_IDX_CH0C: cc0_q <= wbyte_q[`TCC_CC_W-1:0];
                    `TCC_IDX_CH1C: cc1_q <= wbyte_q[`TCC_CC_W-2:0];
                    `TCC_IDX_MASK: mask_q <= wbyte_q[`TCC_ST_W-1:0];
                    default: mask_q <= mask_q;
                endcase
            end
        end
    end

    // The buffered bit of channel 0 disables channel 1 and frees its pin.
    assign cc_eff[0] = cc0_q;
    assign cc_eff[1] = cc0_q[`TCC_CC_MSB] ? {`TCC_CC_W{1'b0}} : {1'b0, cc1_q}; // [R18]

    // ------------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------------

    // External count clock synchroniser; only the second stage reads the first.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            e1_q <= 1'b0;
            e2_q <= 1'b0;
            e3_q <= 1'b0;
            est_q <= 1'b0;
        end
        else
        begin
            e1_q <= ext_clk_pin;
            e2_q <= e1_q;
            e3_q <= e2_q;
            if (e2_q == e3_q)
                est_q <= e3_q;
        end
    end

    assign ext_tick = (e2_q == e3_q) & e3_q & ~est_q;
    assign psmask = `TCC_PS_ALL >> (3'h7 - ctrl_ps_q);
    // The divider gives a one-cycle enable; no derived clock is used.
    assign tick = ~ctrl_stop_q & ~ctrl_rst_q &
                  ((ctrl_ps_q == `TCC_PS_EXT) ? ext_tick : ((pre_q & psmask) == psmask));
    assign ovf = tick & (cnt_q == mod_q); // [R19]

    // Counter wraps to zero on the tick after it reaches the modulo value.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= 16'h0000;
            pre_q <= 7'h00;
        end
        else if (ctrl_rst_q)
        begin
            cnt_q <= 16'h0000;
            pre_q <= 7'h00;
        end
        else
        begin
            if (!ctrl_stop_q)
                pre_q <= pre_q + 7'h01;
            if (ovf)
                cnt_q <= 16'h0000; // [R19]
            else if (tick)
                cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Reading the counter high byte freezes the low byte until it is read.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_lat_q <= 8'h00;
            cnt_held_q <= 1'b0;
        end
        else if (rd_go && ridx == `TCC_IDX_CNTL)
            cnt_held_q <= 1'b0;
        else if (rd_go && ridx == `TCC_IDX_CNTH && !cnt_held_q)
        begin
            cnt_lat_q <= cnt_q[7:0];
            cnt_held_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_chan
            wire [7:0] hi_idx;
            wire [7:0] lo_idx;
            assign hi_idx = (ch == 0) ? `TCC_IDX_CH0H : `TCC_IDX_CH1H;
            assign lo_idx = (ch == 0) ? `TCC_IDX_CH0L : `TCC_IDX_CH1L;
            tcc_chan u_chan
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick),
                .ovf(ovf),
                .cnt(cnt_q),
                .pin_in(channel_pin_in[ch]),
                .ctrl(cc_eff[ch]),
                .wr_hi(wr_go & (widx == hi_idx)),
                .wr_lo(wr_go & (widx == lo_idx)),
                .rd_hi(rd_go & (ridx == hi_idx)),
                .rd_lo(rd_go & (ridx == lo_idx)),
                .wdata(wbyte_q),
                .value_q(value[ch]),
                .event_q(chan_event[ch]),
                .pin_out_q(channel_pin_out[ch]),
                .pin_oe_q(channel_pin_oe[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    assign stat_set = {ovf, chan_event}; // [R17]
    assign stat_clr = (wr_go && widx == `TCC_IDX_STAT) ? wbyte_q[`TCC_ST_W-1:0] : {`TCC_ST_W{1'b0}};

    // Sticky flags, write one to clear; a new event in the clearing cycle survives.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stat_q <= {`TCC_ST_W{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            stat_q <= (stat_q & ~stat_clr) | stat_set; // [R5] [R17]
            irq <= |(stat_q & mask_q);
        end
    end

endmodule // tcc_top
`default_nettype wire

// ===== tcc_sva.sv
// Port-level assertions for the timer channel block, bound into its top module.
`default_nettype none

module tcc_sva
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [1:0] channel_pin_out,
    input wire logic [1:0] channel_pin_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // At release the outputs still show their reset values.
    a_boot_quiet: assert property ($rose(aresetn) |-> channel_pin_oe == 2'h0
        && channel_pin_out == 2'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not clear at reset release");
    a_pins_released: assert property ($rose(aresetn) |-> (channel_pin_oe == 2'h0) [*3])
        else $error("pin driven right after reset");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_locked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open during answer");
    a_rd_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_aw_locked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open during answer");
    // Reads outside the map must be refused with zero data.
    a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:10] != 2'h0
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");

    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_drive: cover property (channel_pin_oe[0] && channel_pin_out[0]);
    c_irq: cover property ($rose(irq));
endmodule // tcc_sva

bind tcc_top tcc_sva chk_u (.*);

`default_nettype wire

// ===== tcc_pins.sv
// Model of the channel pins and external count clock.
`default_nettype none

module tcc_pins
#(
    parameter int DLY = 3
)
(
    input wire logic aclk,
    input wire logic [1:0] lvl,
    output logic [1:0] channel_pin_in = 2'h0,
    output logic ext_clk_pin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q = 3'h0;
    logic [1:0] pend_q = 2'h0;
    int wait_q = 0;

    // A new level shows DLY+1 cycles after it is first seen, as from a slow source.
    always @(posedge aclk)
    begin
        div_q <= div_q + 3'h1;
        ext_clk_pin <= div_q[2];
        if (lvl != pend_q)
        begin
            pend_q <= lvl;
            wait_q <= DLY;
        end
        else if (wait_q > 0)
            wait_q <= wait_q - 1;
        else
            channel_pin_in <= pend_q;
    end
endmodule // tcc_pins

`default_nettype wire

// ===== tcc_top_test.sv
// Self-checking bench of the timer channel block.
`default_nettype none
`include "tcc_map.vh"

module tcc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, ext_clk_pin;
    wire [1:0] s_axi_bresp, s_axi_rresp, channel_pin_in, channel_pin_out, channel_pin_oe;
    wire [31:0] s_axi_rdata;
    logic [1:0] lvl = 0;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [31:0] r = 32'h4e03;
    int n_mismatch = 0, n_checks = 0, cyc = 0;

    always #4 aclk = ~aclk;
    tcc_top dut_u (.*);
    tcc_pins pm_u (.*);

    function [11:0] A(input [7:0] i); A = {2'b00, i, 2'b00}; endfunction
    function [31:0] lf(input [31:0] s); lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction

    task chk(input string nm, input [33:0] s, input [33:0] x);
    begin
        n_checks++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("[FAIL] %s exp %h seen %h", nm, x, s);
        end
    end
    endtask

    // Address and data are offered together and each is dropped once taken.
    task wr(input [11:0] a, input [7:0] d, input [1:0] er);
        logic ad, wd;
    begin
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin ad = 1; s_axi_awvalid <= 0; end
            if (s_axi_wready && !wd) begin wd = 1; s_axi_wvalid <= 0; end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
        chk("bresp", 34'(s_axi_bresp), 34'(er));
    end
    endtask

    // The expected answer is queued; the monitor below compares it.
    task rd(input [11:0] a, input [7:0] d, input [1:0] er);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        q.push_back({er, 24'h0, d});
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    end
    endtask

    task tst(input int t); $display("test %0d done", t); endtask

    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // Read answers are taken off the queue in order.
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = q.pop_front();
            chk("rdata", {s_axi_rresp, s_axi_rdata}, e);
        end
    end

    // A hang ends the run as a failure.
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin n_mismatch++; report_and_stop; end
    end

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(A(`TCC_IDX_CH0C), 8'h00, 0);
        rd(A(`TCC_IDX_CH1C), 8'h00, 0);
        chk("oe", 34'(channel_pin_oe), 34'h0);
        tst(1);
        r = lf(r);
        wr(A(`TCC_IDX_CH0H), r[15:8], 0);
        wr(A(`TCC_IDX_CH0L), r[7:0], 0);
        rd(A(`TCC_IDX_CH0H), r[15:8], 0);
        rd(A(`TCC_IDX_CH0L), r[7:0], 0);
        tst(2);
        // Counter stopped at zero, so a capture stores zero.
        wr(A(`TCC_IDX_CTRL), 8'h03, 0);
        wr(A(`TCC_IDX_CH1H), 8'h5A, 0);
        wr(A(`TCC_IDX_CH1L), 8'hA5, 0);
        wr(A(`TCC_IDX_CH1C), 8'h04, 0);
        wr(A(`TCC_IDX_STAT), 8'h02, 0);
        lvl <= 2'b10;
        repeat (20) @(posedge aclk);
        rd(A(`TCC_IDX_STAT), 8'h02, 0);
        rd(A(`TCC_IDX_CH1H), 8'h00, 0);
        rd(A(`TCC_IDX_CH1L), 8'h00, 0);
        wr(A(`TCC_IDX_STAT), 8'h02, 0);
        rd(A(`TCC_IDX_CH1H), 8'h00, 0);
        lvl <= 2'b00;
        repeat (20) @(posedge aclk);
        lvl <= 2'b10;
        repeat (20) @(posedge aclk);
        rd(A(`TCC_IDX_STAT), 8'h00, 0);
        rd(A(`TCC_IDX_CH1L), 8'h00, 0);
        tst(3);
        wr(A(`TCC_IDX_MODH), 8'h00, 0);
        wr(A(`TCC_IDX_MODL), 8'h20, 0);
        wr(A(`TCC_IDX_CH0H), 8'h00, 0);
        wr(A(`TCC_IDX_CH0L), 8'h10, 0);
        wr(A(`TCC_IDX_MASK), 8'h01, 0);
        wr(A(`TCC_IDX_CH0C), 8'h18, 0);
        wr(A(`TCC_IDX_CTRL), 8'h00, 0);
        repeat (80) @(posedge aclk);
        chk("pin0", 34'(channel_pin_out[0]), 34'h0);
        chk("oe0", 34'(channel_pin_oe[0]), 34'h1);
        chk("irq", 34'(irq), 34'h1);
        wr(A(`TCC_IDX_CH0C), 8'h1B, 0);
        wr(A(`TCC_IDX_MASK), 8'h00, 0);
        repeat (80) @(posedge aclk);
        chk("irq_mask", 34'(irq), 34'h0);
        chk("pin_max", 34'(channel_pin_out[0]), 34'h1);
        wr(A(`TCC_IDX_CTRL), 8'h01, 0);
        wr(A(`TCC_IDX_STAT), 8'h07, 0);
        rd(A(`TCC_IDX_STAT), 8'h00, 0);
        tst(4);
        wr(A(`TCC_IDX_CH1C), 8'h1C, 0);
        repeat (10) @(posedge aclk);
        chk("oe1", 34'(channel_pin_oe[1]), 34'h1);
        wr(A(`TCC_IDX_CH0C), 8'h3C, 0);
        repeat (10) @(posedge aclk);
        chk("oe1_off", 34'(channel_pin_oe[1]), 34'h0);
        tst(5);
        rd(12'h800, 8'h00, 2'h2);
        wr(12'h800, 8'h55, 2'h2);
        tst(6);
        repeat (5) @(posedge aclk);
        report_and_stop;
    end
endmodule // tcc_top_test

`default_nettype wire
